// [pkg/dcu_defines.svh]
`ifndef DCU_DEFINES_SVH
`define DCU_DEFINES_SVH

// Register byte offsets
`define DCU_CTRL_OFS 8'h00
`define DCU_STAT_OFS 8'h04

// Control register fields
`define DCU_CTRL_PAD_LSB 0
`define DCU_CTRL_EN_BIT 4
`define DCU_CTRL_FBEXT_BIT 5
`define DCU_CTRL_WAIT_BIT 6
`define DCU_CTRL_DIV_LSB 8
`define DCU_CTRL_G0_LSB 12
`define DCU_CTRL_G1_LSB 16
`define DCU_CTRL_RST 32'h0000_000F

// Status register fields
`define DCU_STAT_LOCK_BIT 0
`define DCU_STAT_STATE_LSB 1
`define DCU_STAT_TAP_LSB 8
`define DCU_STAT_PER_LSB 16

// Delay line and loop figures; periods in reference clock cycles
`define DCU_TAPS 64
`define DCU_TAP_W 6
`define DCU_PER_MIN 6'h04
`define DCU_PER_MAX 6'h20
`define DCU_LOCK_CNT 4'h8

`endif

// [pkg/dcu_pkg.sv]
package dcu_pkg;
`include "dcu_defines.svh"

  typedef enum logic [1:0] {
    DCU_ST_IDLE = 2'b00,
    DCU_ST_MEASURE = 2'b01,
    DCU_ST_ADJUST = 2'b10,
    DCU_ST_LOCKED = 2'b11
  } dcu_state_t;

  typedef enum logic [2:0] {
    DCU_OUT_P0 = 3'b000,
    DCU_OUT_P90 = 3'b001,
    DCU_OUT_P180 = 3'b010,
    DCU_OUT_P270 = 3'b011,
    DCU_OUT_X2 = 3'b100,
    DCU_OUT_DIV = 3'b101
  } dcu_out_sel_t;

  typedef struct packed {
    logic [`DCU_TAPS-1:0] line;
    logic [3:0] dout;
  } dcu_dly_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [3:0] gbuf;
    logic src_prev;
    logic fb_prev;
    logic seen;
    logic [5:0] cnt;
    logic [5:0] period;
    logic [5:0] tap;
    logic [3:0] match;
    dcu_state_t state;
    logic locked;
    logic x2;
    logic [4:0] div_cnt;
    logic div;
    logic [1:0] gclk;
    logic mirror;
    logic cfg_done;
  } dcu_state_s_t;

endpackage : dcu_pkg

// [verilog/dcu_delay_line.sv]
`timescale 1ns/100ps

// Tapped delay element: one reference cycle per tap, four registered taps out
module dcu_delay_line (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic din_i,
  input wire logic [23:0] tap_sel_i,
  output logic [3:0] dout_o
);
  import dcu_pkg::*;

  dcu_dly_state_t q;
  dcu_dly_state_t d;

  always_comb begin
    d = q;
    d.line = {q.line[`DCU_TAPS-2:0], din_i};
    for (int k = 0; k < 4; k++) begin
      d.dout[k] = q.line[tap_sel_i[6*k +: 6]];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout_o = q.dout;

endmodule : dcu_delay_line

// [verilog/dcu_top.sv]
`timescale 1ns/100ps

module dcu_top (
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic [3:0] CLK_PAD_I,
  input wire logic [3:0] FABRIC_CLK_I,
  input wire logic FB_INT_I,
  input wire logic FB_EXT_I,
  input wire logic CFG_DONE_REQ_I,
  output logic [3:0] GBUF_O,
  output logic [1:0] GCLK_O,
  output logic MIRROR_O,
  output logic LOCKED_O,
  output logic CFG_DONE_O
);
  import dcu_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;
  dcu_state_s_t q;
  dcu_state_s_t d;
  logic [3:0] phase;
  logic [23:0] tap_sel;

  // Quarter-period tap offset from the loop tap
  function automatic logic [5:0] phase_tap(input logic [5:0] tap, input logic [5:0] per, input logic [1:0] k);
    logic [7:0] sum;
    sum = {2'b00, tap} + ({6'h00, k} * {4'h0, per[5:2]});
    return sum[5:0];
  endfunction : phase_tap

  // Last quarter-period edge count of a divided half period; minus one so divide by 16 fits five bits
  function automatic logic [4:0] div_limit(input logic [2:0] sel);
    case (sel)
      3'h0: div_limit = 5'h02;
      3'h1: div_limit = 5'h03;
      3'h2: div_limit = 5'h04;
      3'h3: div_limit = 5'h05;
      3'h4: div_limit = 5'h07;
      3'h5: div_limit = 5'h09;
      3'h6: div_limit = 5'h0F;
      3'h7: div_limit = 5'h1F;
      default: div_limit = 5'h1F;
    endcase
  endfunction : div_limit

  function automatic logic out_mux(input logic [2:0] sel, input logic [3:0] ph, input logic x2, input logic dv);
    case (sel)
      DCU_OUT_P0: out_mux = ph[0];
      DCU_OUT_P90: out_mux = ph[1];
      DCU_OUT_P180: out_mux = ph[2];
      DCU_OUT_P270: out_mux = ph[3];
      DCU_OUT_X2: out_mux = x2;
      DCU_OUT_DIV: out_mux = dv;
      default: out_mux = 1'b0;
    endcase
  endfunction : out_mux

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      tap_sel[6*k +: 6] = phase_tap(q.tap, q.period, 2'(k));
    end
  end

  dcu_delay_line u_delay (
    .clk_i(REF_CLK_I),
    .rst_n_i(rst_n),
    .din_i(q.gbuf[0]),
    .tap_sel_i(tap_sel),
    .dout_o(phase)
  );

  always_comb begin
    logic src_rise;
    logic fb;
    logic fb_rise;
    logic [5:0] err;
    logic en;
    logic x2_now;
    logic [4:0] lim;
    src_rise = 1'b0;
    fb = 1'b0;
    fb_rise = 1'b0;
    err = 6'h00;
    en = 1'b0;
    x2_now = 1'b0;
    lim = 5'h00;
    d = q;

    // Wishbone slave, answer one cycle after request, dropped the next
    d.ack = WB_CYC_I && WB_STB_I && !q.ack;
    d.rdata = 32'h0000_0000;
    if (WB_CYC_I && WB_STB_I && !q.ack) begin
      if (WB_ADR_I == `DCU_CTRL_OFS) begin
        d.rdata = q.ctrl;
        if (WB_WE_I) begin
          for (int b = 0; b < 4; b++) begin
            if (WB_SEL_I[b]) begin
              d.ctrl[8*b +: 8] = WB_DAT_I[8*b +: 8];
            end
          end
        end
      end else if (WB_ADR_I == `DCU_STAT_OFS) begin
        d.rdata[`DCU_STAT_LOCK_BIT] = q.locked;
        d.rdata[`DCU_STAT_STATE_LSB +: 2] = q.state;
        d.rdata[`DCU_STAT_TAP_LSB +: 6] = q.tap;
        d.rdata[`DCU_STAT_PER_LSB +: 6] = q.period;
      end
    end

    // Global buffers: pad when the bit is set, fabric otherwise
    d.gbuf = (q.ctrl[`DCU_CTRL_PAD_LSB +: 4] & CLK_PAD_I) | (~q.ctrl[`DCU_CTRL_PAD_LSB +: 4] & FABRIC_CLK_I);

    en = q.ctrl[`DCU_CTRL_EN_BIT];
    src_rise = q.gbuf[0] && !q.src_prev;
    d.src_prev = q.gbuf[0];
    // Feedback from the distributed net or from the board return path
    fb = q.ctrl[`DCU_CTRL_FBEXT_BIT] ? FB_EXT_I : FB_INT_I;
    fb_rise = fb && !q.fb_prev;
    d.fb_prev = fb;
    // Cycles since last source rise, saturating so slow clocks never look valid
    if (src_rise) begin
      d.cnt = 6'h01;
    end else if (q.cnt != 6'h3F) begin
      d.cnt = q.cnt + 6'h01;
    end
    err = src_rise ? 6'h00 : q.cnt;

    case (q.state)
      DCU_ST_IDLE: begin
        d.tap = 6'h00;
        d.match = 4'h0;
        d.seen = 1'b0;
        if (en) begin
          d.state = DCU_ST_MEASURE;
        end
      end
      DCU_ST_MEASURE: begin
        if (src_rise) begin
          d.seen = 1'b1;
          if (q.seen && q.cnt >= `DCU_PER_MIN && q.cnt <= `DCU_PER_MAX) begin
            d.period = q.cnt;
            d.tap = 6'h00;
            d.match = 4'h0;
            d.state = DCU_ST_ADJUST;
          end
        end
      end
      DCU_ST_ADJUST, DCU_ST_LOCKED: begin
        if (src_rise && (q.cnt < `DCU_PER_MIN || q.cnt > `DCU_PER_MAX)) begin
          // Input period out of range: start over
          d.seen = 1'b0;
          d.state = DCU_ST_MEASURE;
        end else if (src_rise && q.cnt != q.period) begin
          d.period = q.cnt;
          d.state = DCU_ST_ADJUST;
          d.match = 4'h0;
        end else if (fb_rise) begin
          if (err == 6'h00) begin
            // Feedback edge coincides with an input edge
            if (q.match == `DCU_LOCK_CNT - 4'h1) begin
              d.state = DCU_ST_LOCKED;
            end else begin
              d.match = q.match + 4'h1;
            end
          end else begin
            d.match = 4'h0;
            d.state = DCU_ST_ADJUST;
            // Late feedback shortens the delay, early lengthens it; wraps within one period
            if (err <= {1'b0, q.period[5:1]}) begin
              d.tap = (q.tap == 6'h00) ? q.period - 6'h01 : q.tap - 6'h01;
            end else begin
              d.tap = (q.tap >= q.period - 6'h01) ? 6'h00 : q.tap + 6'h01;
            end
          end
        end
      end
      default: begin
        d.state = DCU_ST_IDLE;
      end
    endcase
    if (!en) begin
      d.state = DCU_ST_IDLE;
    end
    d.locked = (d.state == DCU_ST_LOCKED);

    // Doubled clock from 0 and 90 degree phases
    x2_now = phase[0] ^ phase[1];
    d.x2 = x2_now;
    // Divider counts quarter-period edges so half-integer ratios come out even
    lim = div_limit(q.ctrl[`DCU_CTRL_DIV_LSB +: 3]);
    if (x2_now != q.x2) begin
      if (q.div_cnt >= lim) begin
        d.div_cnt = 5'h00;
        d.div = !q.div;
      end else begin
        d.div_cnt = q.div_cnt + 5'h01;
      end
    end

    d.gclk[0] = out_mux(q.ctrl[`DCU_CTRL_G0_LSB +: 3], phase, q.x2, q.div);
    d.gclk[1] = out_mux(q.ctrl[`DCU_CTRL_G1_LSB +: 3], phase, q.x2, q.div);
    d.mirror = phase[0];
    // Start-up finish held back until lock when asked
    d.cfg_done = CFG_DONE_REQ_I && (!q.ctrl[`DCU_CTRL_WAIT_BIT] || q.locked);
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ctrl <= `DCU_CTRL_RST;
      q.state <= DCU_ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign WB_DAT_O = q.rdata;
  assign WB_ACK_O = q.ack;
  assign GBUF_O = q.gbuf;
  assign GCLK_O = q.gclk;
  assign MIRROR_O = q.mirror;
  assign LOCKED_O = q.locked;
  assign CFG_DONE_O = q.cfg_done;

endmodule : dcu_top

// [dv/dcu_top_assertions.sv]
`timescale 1ns/100ps
module dcu_top_chk (
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic [3:0] CLK_PAD_I,
  input wire logic [3:0] FABRIC_CLK_I,
  input wire logic CFG_DONE_REQ_I,
  input wire logic [3:0] GBUF_O,
  input wire logic LOCKED_O,
  input wire logic CFG_DONE_O
);
  logic [3:0] up_q;
  // Skips the first four edges after release, two of them the synchroniser's
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) up_q <= 4'h0;
    else if (up_q != 4'hF) up_q <= up_q + 4'h1;
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);
  ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("no ack");
  ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I)) else $error("stray ack");
  data_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data without ack");
  buf_source_a: assert property (up_q > 4'h3 |->
    ((GBUF_O ^ $past(CLK_PAD_I)) & (GBUF_O ^ $past(FABRIC_CLK_I))) == 4'h0) else $error("bad buffer source");
  cfg_request_a: assert property (CFG_DONE_O |-> $past(CFG_DONE_REQ_I)) else $error("done unasked");
  cfg_lock_a: assert property (LOCKED_O && CFG_DONE_REQ_I |=> CFG_DONE_O) else $error("done held");
  lock_late_a: assert property (LOCKED_O |-> up_q > 4'hB) else $error("lock too soon");
endmodule : dcu_top_chk

bind dcu_top dcu_top_chk u_chk (.REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CLK_PAD_I(CLK_PAD_I),
  .FABRIC_CLK_I(FABRIC_CLK_I), .CFG_DONE_REQ_I(CFG_DONE_REQ_I), .GBUF_O(GBUF_O),
  .LOCKED_O(LOCKED_O), .CFG_DONE_O(CFG_DONE_O));

// [dv/dcu_clk_src.sv]
`timescale 1ns/100ps
module dcu_clk_src (
  input wire logic clk_i,
  input wire logic [1:0] gclk_i,
  input wire logic mirror_i,
  output logic pad_o,
  output logic fb_int_o,
  output logic fb_ext_o
);
  logic [2:0] cnt_q = 3'h0;
  // Board clock runs free; period 8 so quarters are exact
  always_ff @(posedge clk_i) begin
    cnt_q <= cnt_q + 3'h1;
  end
  assign pad_o = cnt_q[2];
  assign fb_int_o = gclk_i[0];
  assign fb_ext_o = mirror_i;
endmodule : dcu_clk_src

// [dv/dcu_top_bench.sv]
`timescale 1ns/100ps
module dcu_top_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [2:0] pads = 3'h0;
  logic [3:0] fab = 4'h0;
  logic req = 1'b0;
  logic [1:0] gq = 2'h0;
  logic [31:0] rd, q;
  logic ack, src, fbi, fbe, lk, done, mir;
  logic [3:0] gb;
  logic [1:0] gc;
  int num_errors = 0;
  int comparisons = 0;
  int n;
  logic [31:0] tc [12] = '{32'h0001_0051, 32'h0002_0051, 32'h0003_0051, 32'h0004_0051, 32'h0005_0051,
    32'h0005_0151, 32'h0005_0251, 32'h0005_0351, 32'h0005_0451, 32'h0005_0551, 32'h0005_0651, 32'h0005_0751};
  logic [31:0] te [12] = '{2, 4, 6, 4, 12, 16, 20, 24, 32, 40, 64, 128};

  dcu_clk_src src_m (.clk_i(clk), .gclk_i(gc), .mirror_i(mir), .pad_o(src), .fb_int_o(fbi), .fb_ext_o(fbe));
  dcu_top uut (.REF_CLK_I(clk), .RESETN_I(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
    .CLK_PAD_I({pads, src}), .FABRIC_CLK_I(fab), .FB_INT_I(fbi), .FB_EXT_I(fbe), .CFG_DONE_REQ_I(req),
    .GBUF_O(gb), .GCLK_O(gc), .MIRROR_O(mir), .LOCKED_O(lk), .CFG_DONE_O(done));

  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) gq <= gc;

  task automatic final_report();
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic hang();
    num_errors++;
    final_report();
  endtask : hang

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    r = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50) hang();
  endtask : wb

  // Cycles from a rise of network 0 (or 1) to the next rise of network 1
  task automatic meas(input logic from0, output int m);
    int k;
    k = 0;
    m = 0;
    do begin
      @(posedge clk);
      k++;
    end while ((from0 ? gc[0] & ~gq[0] : gc[1] & ~gq[1]) !== 1'b1 && k < 400);
    do begin
      @(posedge clk);
      m++;
    end while ((gc[1] & ~gq[1]) !== 1'b1 && m < 400);
    if (k >= 400 || m >= 400) hang();
  endtask : meas

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, 8'h00, 32'h0, q);
    chk("ctrl", 32'h0000_000F, q);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("lock", 32'h0, q & 32'h1);
    wb(1'b1, 8'h08, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'h08, 32'h0, q);
    chk("unmapped", 32'h0, q);
    pads <= 3'h5;
    fab <= 4'h4;
    repeat (3) @(posedge clk);
    chk("pad buf", 32'h5, {29'h0, gb[3:1]});
    wb(1'b1, 8'h00, 32'h0, q);
    repeat (3) @(posedge clk);
    chk("fabric buf", 32'h2, {29'h0, gb[3:1]});
    req <= 1'b1;
    wb(1'b1, 8'h00, 32'h0005_0051, q);
    repeat (4) @(posedge clk);
    chk("early done", 32'h0, {31'h0, done});
    n = 0;
    while (lk !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000) hang();
    repeat (2) @(posedge clk);
    chk("done", 32'h1, {31'h0, done});
    wb(1'b0, 8'h04, 32'h0, q);
    chk("status", 32'h0008_0007, q & 32'h003F_0007);
    for (int i = 0; i < 12; i++) begin
      wb(1'b1, 8'h00, tc[i], q);
      repeat (2) meas(i < 3, n);
      chk("net1 timing", te[i], n);
    end
    // Board return path as feedback: lock must hold, mirror edges line up with the buffered input
    wb(1'b1, 8'h00, 32'h0005_0071, q);
    repeat (20) @(posedge clk);
    chk("ext lock", 32'h1, {31'h0, lk});
    for (int j = 0; j < 16; j++) begin
      @(posedge clk);
      chk("mirror", {31'h0, gb[0]}, {31'h0, mir});
    end
    wb(1'b1, 8'h00, 32'h0000_0041, q);
    repeat (3) @(posedge clk);
    chk("unlock", 32'h0, {30'h0, lk, done});
    final_report();
  end
endmodule : dcu_top_bench
